// ==== verilog/cwr_pkg.sv ====
// Constants and types for configuration word decode and reset control
package cwr_pkg;
  // Core clock
  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned CLK_NS    = 4;
  // Power-up delay: 64 ms, cycle count rounded down
  localparam int unsigned PUD_MS    = 64;
  localparam int unsigned PUD_CYC   = PUD_MS * (CLK_HZ / 1000);
  localparam int unsigned PUD_W     = 24;
  // Reset pin glitch filter: least width, cycle count rounded up
  localparam int unsigned FILT_NS   = 100;
  localparam int unsigned FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FILT_W    = 5;
  // Oscillator settle: rising edges of the crystal clock
  localparam int unsigned STL_EDGES = 1024;
  localparam int unsigned STL_W     = 11;
  // Configuration word place and layout
  localparam int unsigned CFG_W     = 14;
  localparam logic [13:0] CFG_ADDR  = 14'h2007;
  localparam logic [13:0] CFG_BLANK = 14'h3FFF;
  localparam logic [13:0] RD_IDLE   = 14'h0000;
  localparam int unsigned CFG_RSV_HI    = 13;
  localparam int unsigned CFG_RSV_LO    = 12;
  localparam int unsigned CFG_CM_BIT    = 11;
  localparam int unsigned CFG_SWO_BIT   = 10;
  localparam int unsigned CFG_SD_HI     = 9;
  localparam int unsigned CFG_SD_LO     = 8;
  localparam int unsigned CFG_DPROT_BIT = 7;
  localparam int unsigned CFG_PPROT_BIT = 6;
  localparam int unsigned CFG_XPIN_BIT  = 5;
  localparam int unsigned CFG_PUD_BIT   = 4;
  localparam int unsigned CFG_WDT_BIT   = 3;
  localparam int unsigned CFG_OSC_HI    = 2;
  localparam int unsigned CFG_OSC_LO    = 0;

  // Oscillator select codes
  typedef enum logic [2:0] {
    OSC_LPXTAL = 3'h0,
    OSC_XTAL   = 3'h1,
    OSC_HSXTAL = 3'h2,
    OSC_EXTCLK = 3'h3,
    OSC_INTIO  = 3'h4,
    OSC_INT    = 3'h5,
    OSC_RC_IO  = 3'h6,
    OSC_RC     = 3'h7
  } cwr_osc_e;

  // Supply-drop mode codes
  typedef enum logic [1:0] {
    SD_OFF  = 2'h0,
    SD_SOFT = 2'h1,
    SD_WAKE = 2'h2,
    SD_ON   = 2'h3
  } cwr_sd_e;

  // Reset sequencer states, Gray along hold, delay, settle, run
  typedef enum logic [1:0] {
    FSM_HOLD = 2'h0,
    FSM_PUD  = 2'h1,
    FSM_STL  = 2'h3,
    FSM_RUN  = 2'h2
  } cwr_fsm_e;
endpackage

// ==== verilog/cwr_reset_ctrl.sv ====
// Configuration word decode and internal reset sequencer
// Summary of operation
// - Power-up delay 64 ms, on power-up and supply-drop reset
// - Settle timer holds reset until crystal stable
// - Supply-drop reset may use power-up delay
// - Leave sleep on reset, watchdog, interrupt
// - Programmed bit reads 0, blank reads 1
// - Word at 2007h, read only in programming
// - Bit 11 enables clock monitor
// - Bit 10 enables oscillator switchover
// - Bits 9-8 pick supply-drop reset mode
// - Bit 7 low protects data memory
// - Bit 6 low protects program memory
// - Bit 5 picks reset pin or input
// - Bit 4 high disables power-up delay
// - Bit 3 enables watchdog
// - Bits 2-0 pick one of eight oscillators
// - Supply-drop enable leaves delay bit alone
// - Unprotecting erases the protected memory
// - Pin reset stops internal and RC oscillator
// - Registers reset except on watchdog wake
// - Unaffected registers keep value through resets
// - Watchdog reset never drives the pin
// - Reset pin ignores short pulses
// - Weak pull-up when pin is reset
// - Settle timer starts after power-up delay
// - Supply drop during delay restarts it
`timescale 1ns/10ps
module cwr_reset_ctrl #(
  parameter int unsigned P_PUD_CYC = cwr_pkg::PUD_CYC
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  input  wire logic [cwr_pkg::CFG_W-1:0] i_cfg_word,
  input  wire logic                      i_prog_mode,
  input  wire logic [cwr_pkg::CFG_W-1:0] i_prog_addr,
  input  wire logic                      i_xrst_pin_n,
  input  wire logic                      i_supply_low,
  input  wire logic                      i_osc_pin,
  input  wire logic                      i_soft_sd_en,
  input  wire logic                      i_sleep,
  input  wire logic                      i_wdt_timeout,
  input  wire logic                      i_irq_wake,
  output logic [cwr_pkg::CFG_W-1:0]      o_prog_rdata,
  output logic                           o_core_rst,
  output logic                           o_reg_rst,
  output logic                           o_wake,
  output logic                           o_wdt_en,
  output logic                           o_cm_en,
  output logic                           o_swo_en,
  output logic                           o_dprot,
  output logic                           o_pprot,
  output logic                           o_dmem_erase,
  output logic                           o_pmem_erase,
  output logic [2:0]                     o_osc_mode,
  output logic                           o_osc_stop,
  output logic                           o_xrst_pu_en,
  output logic                           o_pin_din
);
  import cwr_pkg::*;

  localparam logic [PUD_W-1:0]  PUD_LAST  = PUD_W'(P_PUD_CYC - 1);
  localparam logic [STL_W-1:0]  STL_LAST  = STL_W'(STL_EDGES - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC);

  typedef struct packed {
    cwr_fsm_e           fsm;
    logic               pwr_evt;
    logic [PUD_W-1:0]   pud_cnt;
    logic [STL_W-1:0]   stl_cnt;
    logic               xp1;
    logic               xp2;
    logic [FILT_W-1:0]  filt_cnt;
    logic               xflt;
    logic               sd1;
    logic               sd2;
    logic               os1;
    logic               os2;
    logic               os3;
    logic [CFG_W-1:0]   cfg_prev;
    logic [CFG_W-1:0]   rdata;
    logic               wake;
    logic               derase;
    logic               perase;
  } cwr_state_s;

  localparam cwr_state_s ST_RESET = '{
    fsm: FSM_HOLD, pwr_evt: 1'b1, pud_cnt: '0, stl_cnt: '0,
    xp1: 1'b1, xp2: 1'b1, filt_cnt: '0, xflt: 1'b0,
    sd1: 1'b0, sd2: 1'b0, os1: 1'b0, os2: 1'b0, os3: 1'b0,
    cfg_prev: CFG_BLANK, rdata: RD_IDLE, wake: 1'b0,
    derase: 1'b0, perase: 1'b0};

  cwr_state_s st_ff;
  cwr_state_s nxt_st;
  cwr_osc_e   osc_sel;
  cwr_sd_e    sd_mode;
  logic       xpin_sel;
  logic       pud_dis;
  logic       xtal;
  logic       sd_en;
  logic       xrst_act;
  logic       wdt_hit;
  logic       wdt_rst;
  logic       sd_rst;
  logic       src_any;
  logic       osc_rise;

  // Field decode; a programmed bit is 0, a blank bit is 1
  // active-low programming sense
  assign osc_sel  = cwr_osc_e'(i_cfg_word[CFG_OSC_HI:CFG_OSC_LO]);
  assign sd_mode  = cwr_sd_e'(i_cfg_word[CFG_SD_HI:CFG_SD_LO]);
  assign xpin_sel = i_cfg_word[CFG_XPIN_BIT];
  assign pud_dis  = i_cfg_word[CFG_PUD_BIT];
  assign xtal     = (osc_sel == OSC_LPXTAL) || (osc_sel == OSC_XTAL) || (osc_sel == OSC_HSXTAL);

  // Supply-drop enable per mode
  // mode field decode
  always_comb begin
    unique case (sd_mode)
      SD_ON:   sd_en = 1'b1;
      SD_WAKE: sd_en = !i_sleep;
      SD_SOFT: sd_en = i_soft_sd_en;
      SD_OFF:  sd_en = 1'b0;
    endcase
  end

  // Reset sources
  // pin reset only when selected
  assign xrst_act = xpin_sel && st_ff.xflt;
  assign wdt_hit  = i_wdt_timeout && i_cfg_word[CFG_WDT_BIT];
  // watchdog in sleep wakes, not resets
  assign wdt_rst  = wdt_hit && !i_sleep;
  assign sd_rst   = sd_en && st_ff.sd2;
  assign src_any  = xrst_act || wdt_rst || sd_rst;
  assign osc_rise = st_ff.os2 && !st_ff.os3;

  // Next state of the whole block
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.xp1 = i_xrst_pin_n;
    nxt_st.xp2 = st_ff.xp1;
    nxt_st.sd1 = i_supply_low;
    nxt_st.sd2 = st_ff.sd1;
    nxt_st.os1 = i_osc_pin;
    nxt_st.os2 = st_ff.os1;
    nxt_st.os3 = st_ff.os2;
    if (st_ff.xp2) begin
      nxt_st.filt_cnt = '0;
      nxt_st.xflt     = 1'b0;
    end else if (st_ff.filt_cnt == FILT_LAST) begin
      nxt_st.xflt     = 1'b1;
    end else begin
      nxt_st.filt_cnt = st_ff.filt_cnt + 1'b1;
    end
    // Sequencer
    unique case (st_ff.fsm)
      FSM_HOLD: begin
        nxt_st.pud_cnt = '0;
        nxt_st.stl_cnt = '0;
        // delay follows only its own bit
        if (!src_any) begin
          if (st_ff.pwr_evt && !pud_dis) begin
            nxt_st.fsm = FSM_PUD;
          end else if (st_ff.pwr_evt && xtal) begin
            nxt_st.fsm = FSM_STL;
          end else begin
            nxt_st.fsm = FSM_RUN;
          end
        end
      end
      FSM_PUD: begin
        if (src_any) begin
          nxt_st.fsm = FSM_HOLD;
        end else if (st_ff.pud_cnt == PUD_LAST) begin
          nxt_st.fsm = xtal ? FSM_STL : FSM_RUN;
        end else begin
          nxt_st.pud_cnt = st_ff.pud_cnt + 1'b1;
        end
      end
      FSM_STL: begin
        if (src_any) begin
          nxt_st.fsm = FSM_HOLD;
        end else if (osc_rise) begin
          if (st_ff.stl_cnt == STL_LAST) begin
            nxt_st.fsm = FSM_RUN;
          end else begin
            nxt_st.stl_cnt = st_ff.stl_cnt + 1'b1;
          end
        end
      end
      FSM_RUN: begin
        if (src_any) begin
          nxt_st.fsm = FSM_HOLD;
        end
      end
    endcase
    // delay armed on power-up; and on supply drop, set wins
    if (nxt_st.fsm == FSM_RUN) begin
      nxt_st.pwr_evt = 1'b0;
    end
    if (sd_rst) begin
      nxt_st.pwr_evt = 1'b1;
    end
    nxt_st.wake = i_sleep && (xrst_act || wdt_hit || i_irq_wake);
    // word visible only in programming mode
    if (i_prog_mode && (i_prog_addr == CFG_ADDR)) begin
      nxt_st.rdata = i_cfg_word;
    end else begin
      nxt_st.rdata = RD_IDLE;
    end
    // erase on protect to unprotect change
    nxt_st.cfg_prev = i_cfg_word;
    nxt_st.derase = i_prog_mode && !st_ff.cfg_prev[CFG_DPROT_BIT]
                    && i_cfg_word[CFG_DPROT_BIT];
    nxt_st.perase = i_prog_mode && !st_ff.cfg_prev[CFG_PPROT_BIT]
                    && i_cfg_word[CFG_PPROT_BIT];
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_core_rst   = (st_ff.fsm != FSM_RUN);
  // register reset; unaffected registers left off this line
  assign o_reg_rst    = o_core_rst;
  assign o_wake       = st_ff.wake;
  assign o_prog_rdata = st_ff.rdata;
  assign o_dmem_erase = st_ff.derase;
  assign o_pmem_erase = st_ff.perase;
  assign o_cm_en      = i_cfg_word[CFG_CM_BIT];
  assign o_swo_en     = i_cfg_word[CFG_SWO_BIT];
  assign o_wdt_en     = i_cfg_word[CFG_WDT_BIT];
  assign o_dprot      = !i_cfg_word[CFG_DPROT_BIT];
  assign o_pprot      = !i_cfg_word[CFG_PPROT_BIT];
  assign o_osc_mode   = osc_sel;
  assign o_osc_stop   = xrst_act && i_cfg_word[CFG_OSC_HI];
  // pull-up; pin is input only, never driven
  assign o_xrst_pu_en = xpin_sel;
  assign o_pin_din    = !xpin_sel && st_ff.xp2;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  src_hold_a: assert property (src_any |=> o_core_rst)
    else $error("reset source did not hold reset");
  pud_restart_a: assert property (
    (st_ff.fsm == FSM_PUD && sd_rst) |=> st_ff.fsm == FSM_HOLD ##1 st_ff.pud_cnt == '0)
    else $error("delay not restarted on supply drop");
  pud_skip_a: assert property (
    (st_ff.fsm == FSM_HOLD && !src_any && pud_dis) |=> st_ff.fsm != FSM_PUD)
    else $error("disabled delay was started");
  pud_once_a: assert property (
    (st_ff.fsm == FSM_HOLD && !src_any && !st_ff.pwr_evt) |=> st_ff.fsm == FSM_RUN)
    else $error("delay ran without power-up event");
  stl_order_a: assert property (
    (st_ff.fsm == FSM_RUN && $past(st_ff.fsm) == FSM_PUD) |-> !$past(xtal))
    else $error("crystal skipped the settle timer");
  wake_src_a: assert property (
    (i_sleep && i_irq_wake) |=> o_wake)
    else $error("interrupt did not wake");
  xpin_off_a: assert property (
    (!xpin_sel && st_ff.fsm == FSM_RUN && !wdt_rst && !sd_rst) |=> !o_core_rst)
    else $error("reset pin acted while deselected");
  osc_stop_a: assert property (
    o_osc_stop |-> osc_sel inside {OSC_INTIO, OSC_INT, OSC_RC_IO, OSC_RC})
    else $error("crystal oscillator stopped");
  sd_off_a: assert property (
    (sd_mode == SD_OFF && st_ff.fsm == FSM_RUN && !xrst_act && !wdt_rst) |=> !o_core_rst)
    else $error("supply drop reset while disabled");
  filt_width_a: assert property (
    $rose(st_ff.xflt) |-> $past(st_ff.filt_cnt) == FILT_LAST)
    else $error("pin filter fired early");
  stl_hold_a: assert property (
    (st_ff.fsm == FSM_STL && !osc_rise && !src_any) |=> st_ff.fsm == FSM_STL)
    else $error("settle ended without crystal edge");
  erase_d_a: assert property (
    (i_prog_mode && !st_ff.cfg_prev[CFG_DPROT_BIT] && i_cfg_word[CFG_DPROT_BIT]) |=> o_dmem_erase)
    else $error("data erase missing");

  pwr_seq_c: cover property (st_ff.fsm == FSM_PUD ##1 st_ff.fsm == FSM_RUN);
  stl_run_c: cover property (st_ff.fsm == FSM_STL ##1 st_ff.fsm == FSM_RUN);
  sd_rest_c: cover property (st_ff.fsm == FSM_PUD && sd_rst);
  wake_c:    cover property (o_wake);
endmodule

// ==== verif/cwr_reset_ctrl_tb_top.sv ====
// Self-checking bench for configuration decode and reset sequencing
`timescale 1ns/10ps
module cwr_reset_ctrl_tb_top;
  import cwr_pkg::*;
  localparam int unsigned PUD = 200;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, i_prog_mode = 1'b0, i_xrst_pin_n = 1'b1;
  logic        i_supply_low = 1'b0, i_osc_pin = 1'b0, i_soft_sd_en = 1'b0, i_sleep = 1'b0;
  logic        i_wdt_timeout = 1'b0, i_irq_wake = 1'b0;
  logic [13:0] i_cfg_word = 14'h3FEB, i_prog_addr = 14'h0000, o_prog_rdata, w, e;
  logic [2:0]  o_osc_mode;
  logic        o_core_rst, o_reg_rst, o_wake, o_wdt_en, o_cm_en, o_swo_en, o_dprot, o_pprot;
  logic        o_dmem_erase, o_pmem_erase, o_osc_stop, o_xrst_pu_en, o_pin_din;
  logic [31:0] seed = 32'h00015511;
  int          n_fail = 0, checked = 0, n, r, k;

  // Core clock, 4 ns period
  always #2 i_core_clk = ~i_core_clk;

  cwr_reset_ctrl #(.P_PUD_CYC(PUD)) cwr_reset_ctrl_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_word(i_cfg_word), .i_prog_mode(i_prog_mode),
    .i_prog_addr(i_prog_addr), .i_xrst_pin_n(i_xrst_pin_n), .i_supply_low(i_supply_low),
    .i_osc_pin(i_osc_pin), .i_soft_sd_en(i_soft_sd_en), .i_sleep(i_sleep),
    .i_wdt_timeout(i_wdt_timeout), .i_irq_wake(i_irq_wake), .o_prog_rdata(o_prog_rdata),
    .o_core_rst(o_core_rst), .o_reg_rst(o_reg_rst), .o_wake(o_wake), .o_wdt_en(o_wdt_en),
    .o_cm_en(o_cm_en), .o_swo_en(o_swo_en), .o_dprot(o_dprot), .o_pprot(o_pprot),
    .o_dmem_erase(o_dmem_erase), .o_pmem_erase(o_pmem_erase), .o_osc_mode(o_osc_mode),
    .o_osc_stop(o_osc_stop), .o_xrst_pu_en(o_xrst_pu_en), .o_pin_din(o_pin_din)
  );

  // Xorshift source with fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Step clocks, land just after the edge
  task automatic cyc(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask

  // Compare and count
  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Closing report
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for reset release, counting cycles
  task automatic wait_rel(input int lim, output int c);
    c = 0;
    while (o_core_rst !== 1'b0 && c < lim) begin
      cyc(1);
      c++;
    end
    if (c >= lim) begin
      n_fail++;
      $display("[FAIL] %0t release timeout", $time);
      test_done();
    end
  endtask

  // Count reset and wake cycles over a window
  task automatic obs(input int len);
    r = 0;
    k = 0;
    repeat (len) begin
      cyc(1);
      r += (o_core_rst !== 1'b0);
      k += (o_wake !== 1'b0);
    end
  endtask

  // Short supply drop
  task automatic drop();
    i_supply_low = 1'b1;
    obs(6);
    i_supply_low = 1'b0;
  endtask

  initial begin
    // Power-up in external clock mode
    repeat (10) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    wait_rel(PUD + 40, n); // Release bounded
    chk(n >= PUD && n <= PUD + 4, 1'b1, "powerup delay"); // Delay length
    // Random words over all oscillator codes, with programming reads
    for (int i = 0; i < 24; i++) begin
      w = 14'(rnd());
      w[2:0] = i[2:0];
      i_cfg_word = w;
      i_prog_mode = i[0] | i[1];
      i_prog_addr = i[2] ? 14'(rnd()) : CFG_ADDR;
      e = (i_prog_mode && i_prog_addr == CFG_ADDR) ? w : RD_IDLE;
      #1;
      chk(o_osc_mode, w[2:0], "osc mode"); // Oscillator code
      chk(o_wdt_en, w[3], "wdt enable"); // Watchdog bit
      chk(o_cm_en, w[11], "monitor"); // Clock monitor
      chk(o_swo_en, w[10], "switchover"); // Switchover
      chk({o_dprot, o_pprot}, {!w[7], !w[6]}, "protect"); // Protect sense
      chk({o_xrst_pu_en, o_pin_din}, {w[5], !w[5]}, "pin role"); // Pin role
      cyc(1);
      chk(o_prog_rdata, e, "prog read"); // Word read
      chk({o_core_rst, o_reg_rst}, 2'b00, "stray reset"); // Reserved bits inert
    end
    // Unprotect while programming gives one erase pulse each
    i_prog_mode = 1'b1;
    i_cfg_word = 14'h3F3F;
    cyc(3);
    i_cfg_word = 14'h3FFF;
    obs(0);
    repeat (4) begin
      cyc(1);
      r += (o_dmem_erase === 1'b1);
      k += (o_pmem_erase === 1'b1);
    end
    chk(r == 1 && k == 1, 1'b1, "erase pulse"); // Erase on unprotect
    i_prog_mode = 1'b0;
    // Pin reset in RC mode: short pulse filtered, long pulse resets
    i_cfg_word = 14'h3FEF;
    i_xrst_pin_n = 1'b0;
    cyc(10);
    i_xrst_pin_n = 1'b1;
    obs(40);
    chk(r == 0, 1'b1, "short pulse"); // Glitch filter
    i_xrst_pin_n = 1'b0;
    cyc(40);
    chk({o_core_rst, o_reg_rst, o_osc_stop}, 3'b111, "pin reset"); // Pin reset
    i_xrst_pin_n = 1'b1;
    wait_rel(60, n); // No power-up delay after pin reset
    // Pin as plain input
    i_cfg_word = 14'h3FCF;
    i_xrst_pin_n = 1'b0;
    obs(40);
    chk({r == 0, o_pin_din}, 2'b10, "pin input"); // Internal reset tied off
    i_xrst_pin_n = 1'b1;
    // Let the pin filter clear before the pin becomes a reset again
    cyc(4);
    // Watchdog: reset when running, disabled, wake in sleep
    for (int j = 0; j < 3; j++) begin
      i_cfg_word = (j == 1) ? 14'h3FE7 : 14'h3FEF;
      i_sleep = (j == 2);
      i_wdt_timeout = 1'b1;
      obs(1);
      i_wdt_timeout = 1'b0;
      e[1:0] = {r != 0, k != 0};
      obs(8);
      e[1:0] = e[1:0] | {r != 0, k != 0};
      chk(e[1:0], {j == 0, j == 2}, "watchdog"); // Reset or wake
      if (j == 0)
        wait_rel(20, n); // Quick release after watchdog
    end
    i_irq_wake = 1'b1;
    obs(4);
    chk({r != 0, k != 0}, 2'b01, "irq wake"); // Interrupt wake
    i_irq_wake = 1'b0;
    i_sleep = 1'b0;
    // Supply drop over every mode, soft enable and sleep
    for (int j = 0; j < 16; j++) begin
      i_cfg_word = {4'hF, j[1:0], 8'hEF};
      i_soft_sd_en = j[2];
      i_sleep = j[3];
      drop();
      e[0] = j[1:0] == 2'h3 || (j[1:0] == 2'h2 && !j[3]) || (j[1:0] == 2'h1 && j[2]);
      chk(r != 0, e[0], "drop mode"); // Mode decode
      if (e[0]) begin
        wait_rel(PUD + 40, n);
        chk(n >= PUD, 1'b1, "drop delay"); // Delay after drop
      end
    end
    i_sleep = 1'b0;
    // Drop again in mid-delay restarts the count
    i_cfg_word = 14'h3FEF;
    drop();
    cyc(PUD / 2);
    drop();
    wait_rel(PUD + 40, n);
    chk(n >= PUD, 1'b1, "drop restart"); // Restart on repeated drop
    // Delay disabled: supply drop alone adds no delay
    i_cfg_word = 14'h3FFF;
    drop();
    wait_rel(60, n); // Delay follows own bit
    // Crystal power-up: settle count starts after the delay
    i_cfg_word = 14'h3FE9;
    i_rst = 1'b1;
    cyc(10);
    i_rst = 1'b0;
    cyc(PUD + 40);
    chk(o_core_rst, 1'b1, "settle hold"); // Held with quiet crystal
    n = 0;
    while (o_core_rst === 1'b1 && n < 1100) begin
      i_osc_pin = 1'b1;
      cyc(2);
      i_osc_pin = 1'b0;
      cyc(2);
      n++;
    end
    chk(n >= STL_EDGES && n <= STL_EDGES + 4, 1'b1, "settle edges"); // Settle count
    test_done();
  end
endmodule
